// ### rtl/pld_output_macrocell.sv
// ten configurable output macrocells of a sum-of-products array, set up over ahb-lite
// Behaviour
// - Ten macrocells in five pairs take 8, 10, 12, 14 and 16 logic product terms.
// - Each macrocell has one more product term that only drives its pin's output enable.
// - Each macrocell's pin polarity is set on its own to true or inverted in either mode.
// - A shared zeroing term clears every register's pin and state at once, with no clock, while it holds; its inverted array feedback goes to one at the next edge.
// - A shared preset term loads one into every register at the first rising edge while it holds and zeroing does not.
// - Zeroing and preset act on the flip-flop itself, so the pin level then follows the polarity.
// - Mode bit zero and mode bit one of each cell pick the polarity and registered or combinatorial.
// - A registered cell drives its pin from its flip-flop through the chosen buffer.
// - A registered cell's pin enable is its own enable product term.
// - A registered cell feeds the inverted flip-flop output to the array in both forms.
// - A registered pin is output only and never feeds the array.
// - A combinatorial cell drives its pin straight from its sum term through the chosen buffer.
// - A combinatorial cell's enable is always on, always off or its enable product term.
// - A combinatorial cell feeds its pin level back to the array in both forms.
`timescale 1ns/100ps
`default_nettype none
`include "pld_output_macrocell_defs.svh"

module pld_output_macrocell (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // dedicated input pins
   input  wire logic [11:0] ded_in,
   // macrocell pins
   input  wire logic [9:0]  io_in,
   output logic [9:0]       io_out,
   output logic [9:0]       io_oe
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [3:0]  cfg_reg  [0:9];
   logic [43:0] fuse_mem [0:171];
   logic [9:0]  q_reg;
   logic [31:0] hrdata_reg;
   logic        wr_pend_reg;
   logic [12:0] wr_addr_reg;
   logic [21:0] sync1_reg;
   logic [21:0] sync2_reg;
   logic [21:0] sync3_reg;
   logic [21:0] pin_filt_reg;

   // ---------------------------------------------------------------
   // array signals
   // ---------------------------------------------------------------
   logic [21:0]  pin_filt_next;
   logic [21:0]  sync_agree;
   logic [9:0]   feedback;
   logic [21:0]  array_sig;
   logic [43:0]  literals;
   logic [171:0] term_val;
   logic [9:0]   sum_term;
   logic [9:0]   q_eff;
   logic         zero_term;
   logic         preset_term;

   // ---------------------------------------------------------------
   // pin input synchroniser
   // ---------------------------------------------------------------

   // three stages; the filtered level moves only when stages two and three agree,
   // so a level that has settled only in stage one never reaches the array
   assign sync_agree    = ~(sync2_reg ^ sync3_reg);
   assign pin_filt_next = (sync_agree & sync3_reg) | (~sync_agree & pin_filt_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg    <= 22'h000000;
         sync2_reg    <= 22'h000000;
         sync3_reg    <= 22'h000000;
         pin_filt_reg <= 22'h000000;
      end else begin
         sync1_reg    <= {io_in, ded_in};
         sync2_reg    <= sync1_reg;
         sync3_reg    <= sync2_reg;
         pin_filt_reg <= pin_filt_next;
      end
   end

   // ---------------------------------------------------------------
   // and array
   // ---------------------------------------------------------------

   // array inputs: dedicated pins, then one feedback per cell, each in true and complement
   // literal j and literal j plus 22 are the two forms of one signal
   assign array_sig = {feedback, pin_filt_reg[11:0]};
   assign literals  = {~array_sig, array_sig};

   // a term with no fuse set is false; otherwise the and of its chosen literals
   // an empty row would otherwise read true and flood every sum
   genvar t;
   generate
      for (t = 0; t < `NUM_TERMS; t++) begin : g_term
         assign term_val[t] = (|fuse_mem[t]) & (&(~fuse_mem[t] | literals));
      end
   endgenerate

   // shared zeroing and preset terms
   assign zero_term   = term_val[`ZERO_TERM_IDX];
   assign preset_term = term_val[`PRESET_TERM_IDX];

   // ---------------------------------------------------------------
   // macrocells
   // ---------------------------------------------------------------
   genvar m;
   generate
      for (m = 0; m < `NUM_CELLS; m++) begin : g_cell
         localparam int NTERMS = `MIN_TERMS + `TERM_STEP * (m / 2);
         localparam logic [16:0] TOP_BIT = 17'h00001 << NTERMS;
         localparam logic [15:0] LOGIC_MASK = 16'(TOP_BIT - 17'h00001);
         logic [1:0] oe_sel;
         logic       is_comb;
         logic       pol_true;
         logic       oe_term;
         logic       pin_raw;
         logic       oe_comb;

         // mode bit zero is polarity, mode bit one picks combinatorial
         assign pol_true = cfg_reg[m][`CFG_POL_BIT];
         assign is_comb  = cfg_reg[m][`CFG_COMB_BIT];
         assign oe_sel   = cfg_reg[m][`CFG_OE_LSB +: 2];

         // or of only as many logic terms as this pair owns
         // slots past that count stay dead even if software fills their fuses
         assign sum_term[m] = |(term_val[m * `TERM_SLOTS +: `LOGIC_SLOTS] & LOGIC_MASK);
         assign oe_term     = term_val[m * `TERM_SLOTS + `OE_SLOT];

         // zeroing masks the flip-flop at once, independent of the clock
         // the flop itself clears on the next edge and stays clear while the term holds
         assign q_eff[m] = q_reg[m] & ~zero_term;

         // zeroing wins, then preset, else the sum term
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               q_reg[m] <= 1'b0;
            end else if (zero_term) begin
               q_reg[m] <= 1'b0;
            end else if (preset_term) begin
               q_reg[m] <= 1'b1;
            end else begin
               q_reg[m] <= sum_term[m];
            end
         end

         // pin source and polarity
         // a released pin still shows its drive value; only io_oe lets go of it
         assign pin_raw   = is_comb ? sum_term[m] : q_eff[m];
         assign io_out[m] = pol_true ? pin_raw : ~pin_raw;

         // enable: product term when registered, chosen source when combinatorial
         assign oe_comb  = (oe_sel == pld_output_macrocell_pkg::OE_ON) ? 1'b1 :
                           (oe_sel == pld_output_macrocell_pkg::OE_OFF) ? 1'b0 : oe_term;
         assign io_oe[m] = is_comb ? oe_comb : oe_term;

         // feedback: pin level when combinatorial, inverted flip-flop when registered
         // registered feedback is already on this clock and skips the synchroniser
         assign feedback[m] = is_comb ? pin_filt_reg[`NUM_DED_IN + m] : ~q_reg[m];
      end
   endgenerate

   // ---------------------------------------------------------------
   // ahb-lite slave decode
   // ---------------------------------------------------------------
   logic        addr_phase;
   logic [12:0] rd_addr;
   logic [12:0] cfg_off;
   logic [12:0] fuse_off;
   logic        rd_is_cfg;
   logic        rd_is_fuse;
   logic [3:0]  rd_cfg_idx;
   logic [8:0]  rd_fuse_word;
   logic [31:0] rd_fuse_data;
   logic [31:0] rd_data;
   logic [12:0] wr_cfg_off;
   logic [12:0] wr_fuse_off;
   logic        wr_is_cfg;
   logic        wr_is_fuse;
   logic [3:0]  wr_cfg_idx;
   logic [8:0]  wr_fuse_word;
   logic        wr_now;
   logic        rd_is_state;
   logic        rd_is_pins;
   logic [7:0]  rd_row;
   logic [7:0]  wr_row;
   logic        cfg_we;
   logic        fuse_lo_we;
   logic        fuse_hi_we;

   // zero wait states, always okay
   // every word is answered from flops or from the array, so nothing needs a stall
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // a transfer is taken on a valid address phase
   assign addr_phase = hsel & hready & htrans[1];
   assign rd_addr    = haddr[12:0];

   // read side address decode
   assign cfg_off      = rd_addr - `ADDR_CFG_BASE;
   assign fuse_off     = rd_addr - `ADDR_FUSE_BASE;
   assign rd_is_cfg    = (rd_addr < (`ADDR_CFG_BASE + `CFG_SPAN)) && (rd_addr[1:0] == 2'b00);
   assign rd_is_fuse   = (rd_addr >= `ADDR_FUSE_BASE) && (fuse_off[12:2] < 11'(`FUSE_WORDS));
   assign rd_is_state  = (rd_addr == `ADDR_STATE);
   assign rd_is_pins   = (rd_addr == `ADDR_PINS);
   assign rd_cfg_idx   = cfg_off[5:2];
   assign rd_fuse_word = fuse_off[10:2];
   assign rd_row       = rd_fuse_word[8:1];

   // the row index overruns the array only outside the fuse window, where the mux ignores it
   assign rd_fuse_data = rd_fuse_word[0] ? {20'h00000, fuse_mem[rd_row][43:32]}
                                         : fuse_mem[rd_row][31:0];

   // read data select; unmapped words read as zero
   assign rd_data = rd_is_cfg   ? {28'h0000000, cfg_reg[rd_cfg_idx]} :
                    rd_is_state ? {22'h000000, q_eff} :
                    rd_is_pins  ? {12'h000, io_oe, io_out} :
                    rd_is_fuse  ? rd_fuse_data : 32'h00000000;

   // write side decode from the held address
   assign wr_cfg_off   = wr_addr_reg - `ADDR_CFG_BASE;
   assign wr_fuse_off  = wr_addr_reg - `ADDR_FUSE_BASE;
   assign wr_is_cfg    = (wr_addr_reg < (`ADDR_CFG_BASE + `CFG_SPAN)) && (wr_addr_reg[1:0] == 2'b00);
   assign wr_is_fuse   = (wr_addr_reg >= `ADDR_FUSE_BASE) && (wr_fuse_off[12:2] < 11'(`FUSE_WORDS));
   assign wr_cfg_idx   = wr_cfg_off[5:2];
   assign wr_fuse_word = wr_fuse_off[10:2];
   assign wr_row       = wr_fuse_word[8:1];
   assign wr_now       = wr_pend_reg & hready;

   // one write strobe per storage target
   assign cfg_we       = wr_now & wr_is_cfg;
   assign fuse_lo_we   = wr_now & wr_is_fuse & ~wr_fuse_word[0];
   assign fuse_hi_we   = wr_now & wr_is_fuse & wr_fuse_word[0];

   // ---------------------------------------------------------------
   // ahb-lite slave state
   // ---------------------------------------------------------------

   // address phase capture and read data
   // read data is taken in the address phase so it stands through the whole data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 13'h0000;
         hrdata_reg  <= 32'h00000000;
      end else begin
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_reg <= rd_addr;
         end
         if (addr_phase && !hwrite) begin
            hrdata_reg <= rd_data;
         end
      end
   end

   // configuration words; settings only change by software writes
   // reset leaves every cell combinatorial, true polarity and released
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `NUM_CELLS; i++) begin
            cfg_reg[i] <= `CFG_RESET;
         end
      end else if (cfg_we) begin
         cfg_reg[wr_cfg_idx] <= hwdata[3:0];
      end
   end

   // fuse rows: even word holds literals 31..0, odd word literals 43..32
   // a read overlapping the data phase of a write to the same word sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `NUM_TERMS; i++) begin
            fuse_mem[i] <= 44'h00000000000;
         end
      end else if (fuse_lo_we) begin
         fuse_mem[wr_row][31:0] <= hwdata;
      end else if (fuse_hi_we) begin
         fuse_mem[wr_row][43:32] <= hwdata[11:0];
      end
   end

endmodule

`default_nettype wire

// ### include/pld_output_macrocell_defs.svh
// offsets, field positions, reset values and sizes of the output macrocell block
`ifndef PLD_OUTPUT_MACROCELL_DEFS_SVH
`define PLD_OUTPUT_MACROCELL_DEFS_SVH

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define NUM_CELLS      10
`define NUM_DED_IN     12
`define NUM_SIGNALS    22
`define NUM_LITERALS   44
`define TERM_SLOTS     17
`define LOGIC_SLOTS    16
`define OE_SLOT        16
`define MIN_TERMS      8
`define TERM_STEP      2
`define ZERO_TERM_IDX  170
`define PRESET_TERM_IDX 171
`define NUM_TERMS      172

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define ADDR_CFG_BASE  13'h0000
`define CFG_SPAN       13'h0028
`define ADDR_STATE     13'h0040
`define ADDR_PINS      13'h0044
`define ADDR_FUSE_BASE 13'h0400
`define FUSE_WORDS     344

// ---------------------------------------------------------------
// configuration word fields and reset value
// ---------------------------------------------------------------
`define CFG_POL_BIT    0
`define CFG_COMB_BIT   1
`define CFG_OE_LSB     2
`define CFG_WIDTH      4
`define CFG_RESET      4'hb

`endif

// ### include/pld_output_macrocell_pkg.sv
// types shared by the output macrocell block
`default_nettype none

package pld_output_macrocell_pkg;

   // output enable choice for a combinatorial cell
   typedef enum logic [1:0] {
      OE_TERM = 2'b00,
      OE_ON   = 2'b01,
      OE_OFF  = 2'b10
   } oe_sel_t;

   typedef logic [43:0] fuse_row_t;

endpackage

`default_nettype wire

// ### dv/pld_output_macrocell_sva.sv
// assertions on the bus and pin ports of the output macrocell block
`timescale 1ns/100ps
`default_nettype none

module macrocell_checker (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // pins
   input wire logic [9:0]  io_out,
   input wire logic [9:0]  io_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // read address phase taken
   logic rd_take;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;

   ready_always_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
   okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   read_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved without read");
   reset_pins_a: assert property ($rose(hresetn) |-> io_oe == 10'h000 && io_out == 10'h000)
      else $error("pins active after reset");
   reset_data_a: assert property ($rose(hresetn) |-> hrdata == 32'h0) else $error("hrdata not zero after reset");
   pins_read_a: assert property (rd_take && haddr[12:0] == 13'h0044 |=>
      hrdata == {12'h000, $past(io_oe), $past(io_out)}) else $error("pin summary read wrong");
   unmapped_zero_a: assert property (rd_take && haddr[12:0] inside {[13'h0048:13'h03fc]} |=>
      hrdata == 32'h0) else $error("unmapped read not zero");
   state_width_a: assert property (rd_take && haddr[12:0] == 13'h0040 |=> hrdata[31:10] == 22'h0)
      else $error("state word wider than ten cells");

   cover property (rd_take && haddr[12:0] == 13'h0040);
   cover property (rd_take && haddr[12:0] == 13'h0044);
   cover property (io_oe != 10'h000);
endmodule

bind pld_output_macrocell macrocell_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .io_out(io_out), .io_oe(io_oe));

`default_nettype wire

// ### dv/board_model.sv
// board around the macrocell pins: resolves each shared pin wire
`timescale 1ns/100ps
`default_nettype none

module board_model (
   // drive from the block
   input  wire logic [9:0] io_out,
   input  wire logic [9:0] io_oe,
   // drive from the board
   input  wire logic [9:0] drv_val,
   input  wire logic [9:0] drv_en,
   // resolved level
   output logic      [9:0] io_in
);
   // a pin nobody drives floats up to the pull-up level
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         io_in[i] = io_oe[i] ? io_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
      end
   end
endmodule

`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the output macrocell block
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [11:0] ded_in;
   logic [9:0]  io_in, io_out, io_oe, drv_val, drv_en;
   int          fail_count;
   int          n_compared;

   pld_output_macrocell u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ded_in(ded_in), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   board_model u_board (.io_out(io_out), .io_oe(io_oe), .drv_val(drv_val), .drv_en(drv_en), .io_in(io_in));

   // free-running clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // one single transfer, held until ready is seen
   task automatic bus(input logic [12:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {19'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      check("hrdata", exp, q & mask);
   endtask
   // both words of one product term row
   task automatic term(input int t, input logic [43:0] l);
      wr(13'h0400 + 13'(8 * t), l[31:0]);
      wr(13'h0404 + 13'(8 * t), {20'h0, l[43:32]});
   endtask
   function automatic logic [43:0] lit(input int j);
      return 44'h1 << j;
   endfunction
   function automatic logic [31:0] pin(input int i);
      return {30'h0, io_oe[i], io_out[i]};
   endfunction
   // pin inputs pass a synchroniser of four edges
   task automatic settle;
      repeat (6) @(posedge hclk);
      #1;
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #100000;
      fail_count++;
      conclude();
   end

   // test sequence
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, ded_in, drv_val, drv_en} = '0;
      hresetn = 1'b0;
      hsize = 3'h2;
      fail_count = 0;
      n_compared = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(13'h0000, 32'hf, 32'hb);
      rd_chk(13'h0044, 32'hffffffff, 32'h0);
      wr(13'h0100, 32'hffffffff);
      rd_chk(13'h0100, 32'hffffffff, 32'h0);
      // combinatorial cell: and of literals, or of terms
      wr(13'h0000, 32'h7);
      term(0, lit(0) | lit(1));
      term(1, lit(2));
      for (int v = 0; v < 8; v++) begin
         @(posedge hclk);
         ded_in <= 12'(v);
         settle();
         check("pin0", {30'h0, 1'b1, (v[0] & v[1]) | v[2]}, pin(0));
      end
      wr(13'h0000, 32'h6);
      @(posedge hclk);
      ded_in <= 12'h000;
      settle();
      check("pin0", 32'h3, pin(0));
      // enable from its own term, then forced off
      wr(13'h0004, 32'h3);
      term(33, lit(3));
      for (int v = 0; v < 2; v++) begin
         @(posedge hclk);
         ded_in <= 12'(v << 3);
         settle();
         check("oe1", 32'(v), {31'h0, io_oe[1]});
      end
      wr(13'h0004, 32'hb);
      settle();
      check("oe1", 32'h0, {31'h0, io_oe[1]});
      // released pin driven by the board feeds the array
      wr(13'h0000, 32'hb);
      wr(13'h0010, 32'h7);
      term(68, lit(12));
      for (int v = 0; v < 2; v++) begin
         @(posedge hclk);
         drv_en[0] <= 1'b1;
         drv_val[0] <= 1'(v);
         settle();
         check("pin4", {30'h0, 1'b1, 1'(v)}, pin(4));
      end
      // registered cell with zeroing and preset
      wr(13'h0008, 32'h1);
      wr(13'h0014, 32'h7);
      wr(13'h0020, 32'h7);
      term(34, lit(4));
      term(50, lit(33));
      term(85, lit(14));
      term(151, lit(7));
      term(9, lit(7));
      term(170, lit(5));
      term(171, lit(6));
      @(posedge hclk);
      ded_in <= 12'h010;
      settle();
      check("pin2", 32'h3, pin(2));
      check("pin5", 32'h2, pin(5));
      rd_chk(13'h0040, 32'h4, 32'h4);
      @(posedge hclk);
      ded_in <= 12'h030;
      settle();
      check("pin2", 32'h2, pin(2));
      check("pin5", 32'h3, pin(5));
      rd_chk(13'h0040, 32'h4, 32'h0);
      @(posedge hclk);
      ded_in <= 12'h040;
      settle();
      rd_chk(13'h0040, 32'h4, 32'h4);
      wr(13'h0008, 32'h0);
      settle();
      check("pin2", 32'h2, pin(2));
      @(posedge hclk);
      ded_in <= 12'h8c0;
      settle();
      check("pin2", 32'h0, pin(2));
      check("pin8", 32'h3, pin(8));
      check("pin0", 32'h0, {31'h0, io_out[0]});
      conclude();
   end
endmodule

`default_nettype wire
